// file: shared/obf_pkg.sv
`default_nettype none
package obf_pkg;
    // register byte offsets
    localparam logic [3:0] OBF_CFG_OFS  = 4'h0;
    localparam logic [3:0] OBF_STAT_OFS = 4'h4;
    localparam logic [3:0] OBF_DATA_OFS = 4'h8;
    // configuration register fields
    localparam int OBF_CFG_RANGE_POS = 0;
    localparam int OBF_CFG_CMODE_POS = 2;
    localparam int OBF_CFG_TWOS_POS  = 4;
    localparam int OBF_CFG_W         = 5;
    localparam logic [4:0] OBF_CFG_RST  = 5'h00;
    // status register fields
    localparam int OBF_ST_MODE_POS = 0;
    localparam int OBF_ST_REF_POS  = 4;
    localparam int OBF_ST_BUF_POS  = 5;
    localparam int OBF_ST_MIS_POS  = 6;
    localparam int OBF_ST_CUR_POS  = 7;
    localparam int OBF_ST_SWC_POS  = 8;
    localparam int OBF_ST_CNT_POS  = 16;
    // data path sizes and reset values
    localparam int OBF_RES_W   = 18;
    localparam int OBF_FIFO_D  = 16;
    localparam logic OBF_CODING_RST = 1'b1;
    // bus width selection, one-hot
    typedef enum logic [3:0] {
        OBF_PAR18  = 4'h1,
        OBF_PAR16  = 4'h2,
        OBF_PAR8   = 4'h4,
        OBF_SERIAL = 4'h8
    } obf_mode_t;
    // pins sampled from outside the clock domain
    typedef struct packed {
        logic       width_hi;
        logic       width_lo;
        logic       cfg_pin;
        logic       ref_pd;
        logic       buf_pd;
        logic       rd_n;
        logic [1:0] range;
        logic [1:0] cmode;
    } obf_pins_t;
endpackage
`default_nettype wire

// file: rtl/obf_top.sv
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module obf_fifo #(
    parameter int W = 18,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data,
    output logic [$clog2(D):0] count
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] wp_nxt;
    logic [AW-1:0] rp_r;
    logic [AW-1:0] rp_nxt;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          push;
    logic          pop;

    // honest flags straight from the fill count
    assign in_ready  = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign count     = cnt_r;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count arithmetic
    always_comb begin
        wp_nxt  = push ? wp_r + AW'(1) : wp_r;
        rp_nxt  = pop ? rp_r + AW'(1) : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + (AW+1)'(1);
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else if (clk_en) begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage has no reset; only written entries are ever read
    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module obf_top
    import obf_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [3:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // conversion results from the converter core
    input  wire logic                 res_valid,
    output logic                      res_ready,
    input  wire logic [OBF_RES_W-1:0] res_data,
    // configuration pins and the host read strobe
    input  wire logic                 bus_width_sel_hi,
    input  wire logic                 bus_width_sel_lo,
    input  wire logic                 pin_or_register_config,
    input  wire logic                 ref_powerdown,
    input  wire logic                 ref_buffer_powerdown,
    input  wire logic                 read_n,
    input  wire logic [1:0]           range_pins,
    input  wire logic [1:0]           conv_mode_pins,
    // data lines, split into in, out and enable
    input  wire logic [OBF_RES_W-1:0] data_line_i,
    output logic [OBF_RES_W-1:0]      data_line_o,
    output logic [OBF_RES_W-1:0]      data_line_oe,
    // derived controls
    output logic                      output_coding_sel,
    output logic                      serial_if_en,
    output logic [1:0]                range_sel,
    output logic [1:0]                conv_mode_sel,
    output logic                      ref_enable,
    output logic                      ref_buf_enable
);
    localparam int CW = $clog2(OBF_FIFO_D) + 1;

    obf_pins_t pins_raw;
    obf_pins_t pins_s1_r;
    obf_pins_t pins_r;
    logic [OBF_RES_W-1:0] line_s1_r;
    logic [OBF_RES_W-1:0] line_r;
    logic      rd_n_d_r;
    logic      word_select_low;
    logic      byte_select_high;
    obf_mode_t mode;
    logic      sw_cfg;

    ////////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers on every pin input
    assign pins_raw = '{width_hi: bus_width_sel_hi, width_lo: bus_width_sel_lo,
                        cfg_pin: pin_or_register_config, ref_pd: ref_powerdown,
                        buf_pd: ref_buffer_powerdown, rd_n: read_n,
                        range: range_pins, cmode: conv_mode_pins};

    // read strobe resets to its idle high level so no false release follows reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_s1_r <= '{rd_n: 1'b1, default: '0};
            pins_r    <= '{rd_n: 1'b1, default: '0};
            line_s1_r <= '0;
            line_r    <= '0;
            rd_n_d_r  <= 1'b1;
        end else if (clk_en) begin
            pins_s1_r <= pins_raw;
            pins_r    <= pins_s1_r;
            line_s1_r <= data_line_i;
            line_r    <= line_s1_r;
            rd_n_d_r  <= pins_r.rd_n;
        end
    end

    // width selects decode to one of four bus modes
    always_comb begin
        case ({pins_r.width_hi, pins_r.width_lo})
            2'b00:   mode = OBF_PAR18;
            2'b01:   mode = OBF_PAR16;
            2'b10:   mode = OBF_PAR8;
            default: mode = OBF_SERIAL;
        endcase
    end

    // line 1 doubles as word select in 16- and 8-bit modes, line 2 as byte select in 8-bit mode
    assign word_select_low  = line_r[1];
    assign byte_select_high = line_r[2];
    assign serial_if_en     = (mode == OBF_SERIAL);
    assign sw_cfg = serial_if_en && !pins_r.cfg_pin;

    ////////////////////////////////////////////////////////////////////////////
    // result buffer and the word currently presented
    logic [OBF_RES_W-1:0] fifo_data;
    logic                 fifo_valid;
    logic                 fifo_take;
    logic [CW-1:0]        fifo_cnt;
    logic [OBF_RES_W-1:0] cur_r;
    logic [OBF_RES_W-1:0] cur_nxt;
    logic                 cur_vld_r;
    logic                 cur_vld_nxt;
    logic                 read_done;

    obf_fifo #(.W(OBF_RES_W), .D(OBF_FIFO_D)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .in_valid  (res_valid),
        .in_ready  (res_ready),
        .in_data   (res_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_take),
        .out_data  (fifo_data),
        .count     (fifo_cnt)
    );

    // end of a host read releases the word; the host stalls the drain
    assign read_done = pins_r.rd_n && !rd_n_d_r;
    assign fifo_take = !cur_vld_r || read_done;

    always_comb begin
        cur_nxt     = cur_r;
        cur_vld_nxt = cur_vld_r;
        if (fifo_take) begin
            cur_vld_nxt = fifo_valid;
            if (fifo_valid) begin
                cur_nxt = fifo_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_r     <= '0;
            cur_vld_r <= 1'b0;
        end else if (clk_en) begin
            cur_r     <= cur_nxt;
            cur_vld_r <= cur_vld_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data line formatting, registered so the pins never glitch
    logic [OBF_RES_W-1:0] d_r;
    logic [OBF_RES_W-1:0] d_nxt;
    logic [OBF_RES_W-1:0] oe_r;
    logic [OBF_RES_W-1:0] oe_nxt;

    always_comb begin
        d_nxt  = '0;
        oe_nxt = '0;
        case (mode)
            OBF_PAR18: begin
                d_nxt  = cur_r;
                oe_nxt = '1;
            end
            OBF_PAR16: begin
                oe_nxt[17:2] = '1;
                if (!word_select_low) begin
                    d_nxt[17:2] = cur_r[17:2];
                end else begin
                    d_nxt[3:2] = cur_r[1:0];
                end
            end
            OBF_PAR8: begin
                oe_nxt[17:10] = '1;
                case ({word_select_low, byte_select_high})
                    2'b00:   d_nxt[17:10] = cur_r[17:10];
                    2'b01:   d_nxt[17:10] = cur_r[9:2];
                    2'b10:   d_nxt[11:10] = cur_r[1:0];
                    default: d_nxt[17:16] = cur_r[1:0];
                endcase
            end
            default: begin
                oe_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            d_r  <= '0;
            oe_r <= '0;
        end else if (clk_en) begin
            d_r  <= d_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign data_line_o  = d_r;
    assign data_line_oe = oe_r;

    ////////////////////////////////////////////////////////////////////////////
    // configuration register and derived selections
    logic [OBF_CFG_W-1:0] cfg_r;
    logic [OBF_CFG_W-1:0] cfg_nxt;
    logic                 coding_r;
    logic                 coding_nxt;
    logic                 wb_req;
    logic                 ack_r;
    logic                 ack_nxt;
    logic [31:0]          rdat_r;
    logic [31:0]          rdat_nxt;
    logic [31:0]          status;

    // coding is an input on line 0 except at full width
    always_comb begin
        if (mode == OBF_PAR18) begin
            coding_nxt = !cfg_r[OBF_CFG_TWOS_POS];
        end else begin
            coding_nxt = line_r[0];
        end
    end

    always_comb begin
        if (sw_cfg) begin
            range_sel     = cfg_r[OBF_CFG_RANGE_POS +: 2];
            conv_mode_sel = cfg_r[OBF_CFG_CMODE_POS +: 2];
        end else begin
            range_sel     = pins_r.range;
            conv_mode_sel = pins_r.cmode;
        end
    end

    assign ref_enable        = !pins_r.ref_pd;
    assign ref_buf_enable    = !pins_r.buf_pd;
    assign output_coding_sel = coding_r;

    // status shows live state; misuse flags internal ref without buffer
    always_comb begin
        status = '0;
        status[OBF_ST_MODE_POS +: 4] = mode;
        status[OBF_ST_REF_POS]       = ref_enable;
        status[OBF_ST_BUF_POS]       = ref_buf_enable;
        status[OBF_ST_MIS_POS]       = ref_enable && !ref_buf_enable;
        status[OBF_ST_CUR_POS]       = cur_vld_r;
        status[OBF_ST_SWC_POS]       = sw_cfg;
        status[OBF_ST_CNT_POS +: CW] = fifo_cnt;
    end

    // single-wait-state slave: ack one cycle after the request
    assign wb_req = wb_cyc_i && wb_stb_i;

    always_comb begin
        ack_nxt  = wb_req && !ack_r;
        rdat_nxt = '0;
        cfg_nxt  = cfg_r;
        case (wb_adr_i)
            OBF_CFG_OFS:  rdat_nxt[OBF_CFG_W-1:0] = cfg_r;
            OBF_STAT_OFS: rdat_nxt = status;
            OBF_DATA_OFS: rdat_nxt[OBF_RES_W-1:0] = cur_r;
            default:      rdat_nxt = '0;
        endcase
        // write lands at the acking edge, low lane only
        if (wb_req && ack_r && wb_we_i && wb_sel_i[0] && wb_adr_i == OBF_CFG_OFS) begin
            cfg_nxt = wb_dat_i[OBF_CFG_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r    <= OBF_CFG_RST;
            coding_r <= OBF_CODING_RST;
            ack_r    <= 1'b0;
            rdat_r   <= '0;
        end else if (clk_en) begin
            cfg_r    <= cfg_nxt;
            coding_r <= coding_nxt;
            ack_r    <= ack_nxt;
            rdat_r   <= rdat_nxt;
        end
    end

    // ack gated by the live request so a dropped cycle never sees it
    assign wb_ack_o = ack_r && wb_req;
    assign wb_dat_o = rdat_r;
endmodule
`default_nettype wire

// file: tb/obf_chk.sv
`timescale 1ns/100ps
`default_nettype none
module obf_chk
    import obf_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 clk_en,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_ack_o,
    input wire logic                 bus_width_sel_hi,
    input wire logic                 bus_width_sel_lo,
    input wire logic                 ref_powerdown,
    input wire logic                 ref_buffer_powerdown,
    input wire logic                 ref_enable,
    input wire logic                 ref_buf_enable,
    input wire logic                 serial_if_en,
    input wire logic [OBF_RES_W-1:0] data_line_o,
    input wire logic [OBF_RES_W-1:0] data_line_oe,
    input wire logic                 output_coding_sel
);
    logic [2:0] stab_r;
    logic [2:0] stab_nxt;
    logic [1:0] m_r;
    wire logic [1:0] md = {bus_width_sel_hi, bus_width_sel_lo};
    // counter lags the pins by one sample; a frozen block settles nothing
    wire logic       settled = (stab_r == 3'h7) && (md == m_r) && clk_en;
    ////////////////////////////////////////
    // cycles with width pins unchanged; mode checks wait out the synchroniser
    always_comb begin
        stab_nxt = stab_r;
        if (md != m_r || !clk_en)
            stab_nxt = 3'h0;
        else if (stab_r != 3'h7)
            stab_nxt = stab_r + 3'h1;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stab_r <= 3'h0;
            m_r <= 2'h0;
        end else begin
            stab_r <= stab_nxt;
            m_r <= md;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i && $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_reset_state: assert property ($rose(rst_n) |-> data_line_o == '0 && data_line_oe == '0 && output_coding_sel)
        else $error("outputs not cleared by reset");
    a_ref_follow: assert property (settled && $stable(ref_powerdown)[*4] |-> ref_enable == !ref_powerdown)
        else $error("reference enable wrong");
    a_buf_follow: assert property (settled && $stable(ref_buffer_powerdown)[*4]
        |-> ref_buf_enable == !ref_buffer_powerdown)
        else $error("buffer enable wrong");
    a_full_width: assert property (settled && md == 2'b00 |-> &data_line_oe)
        else $error("full word not driven");
    a_word_inputs: assert property (settled && md == 2'b01 |-> data_line_oe == 18'h3fffc)
        else $error("word mode enables wrong");
    a_byte_hiz: assert property (settled && md == 2'b10 |-> data_line_oe == 18'h3fc00)
        else $error("byte mode enables wrong");
    a_serial_free: assert property (settled && md == 2'b11 |-> data_line_oe == '0 && serial_if_en)
        else $error("serial mode lines not released");
endmodule
bind obf_top obf_chk chk_u (.clk, .rst_n, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .bus_width_sel_hi,
    .bus_width_sel_lo, .ref_powerdown, .ref_buffer_powerdown, .ref_enable, .ref_buf_enable, .serial_if_en,
    .data_line_o, .data_line_oe, .output_coding_sel);
`default_nettype wire

// file: tb/obf_host.sv
`timescale 1ns/100ps
`default_nettype none
module obf_host
    import obf_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 rd_req,
    input wire logic [2:0]           pin_drv,
    input wire logic                 ext_ref,
    input wire logic                 buf_off,
    input wire logic [OBF_RES_W-1:0] dl_o,
    input wire logic [OBF_RES_W-1:0] dl_oe,
    output logic                     read_n,
    output logic                     buf_pd,
    output logic [OBF_RES_W-1:0]     dl_i
);
    logic rd_r = 1'b0;
    logic [OBF_RES_W-1:0] last_r = '0;
    ////////////////////////////////////////
    // strobe moves only after an edge
    always @(posedge clk) rd_r <= rd_req;
    assign read_n = ~rd_r;
    // buffer may sleep only with an external reference
    assign buf_pd = ext_ref & buf_off;
    // host drives lines 0..2 when released; loose lines flip so no stale value survives
    always @(posedge clk) last_r <= dl_i;
    wire logic [OBF_RES_W-1:0] drv = {~last_r[OBF_RES_W-1:3], pin_drv};
    assign dl_i = (dl_oe & dl_o) | (~dl_oe & drv);
endmodule
`default_nettype wire

// file: tb/obf_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module obf_top_tb;
    import obf_pkg::*;
    localparam logic [17:0] W0 = 18'h2d5a3;
    logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, res_valid = 1'b0, rd_req = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic wb_ack_o, res_ready, read_n, ref_buffer_powerdown, output_coding_sel, serial_if_en, ref_enable;
    logic ref_buf_enable, bus_width_sel_hi = 1'b0, bus_width_sel_lo = 1'b0, pin_or_register_config = 1'b1;
    logic ref_powerdown = 1'b0, buf_off = 1'b0;
    logic [17:0] res_data = 18'h0, data_line_i, data_line_o, data_line_oe;
    logic [1:0] range_pins = 2'h1, conv_mode_pins = 2'h1, range_sel, conv_mode_sel;
    logic [2:0] pin_drv = 3'h0;
    logic [35:0] e;
    int miscompares = 0, n_compared = 0, n;
    always #50 clk = ~clk;
    obf_top dut_u (.clk, .rst_n, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .res_valid, .res_ready, .res_data, .bus_width_sel_hi, .bus_width_sel_lo,
        .pin_or_register_config, .ref_powerdown, .ref_buffer_powerdown, .read_n, .range_pins,
        .conv_mode_pins, .data_line_i, .data_line_o, .data_line_oe, .output_coding_sel, .serial_if_en,
        .range_sel, .conv_mode_sel, .ref_enable, .ref_buf_enable);
    obf_host host_u (.clk, .rd_req, .pin_drv, .ext_ref(ref_powerdown), .buf_off, .dl_o(data_line_o),
        .dl_oe(data_line_oe), .read_n, .buf_pd(ref_buffer_powerdown), .dl_i(data_line_i));
    ////////////////////////////////////////
    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", s, x, g);
        end
    endtask
    // classic single cycle; the wait for ack is bounded
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            give_verdict();
        end
        // data taken at the acking edge, then the request is released
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk);
    endtask
    // read strobe pulse, then time for sync, release and reload
    task automatic rd;
        @(posedge clk);
        rd_req <= 1'b1;
        @(posedge clk);
        rd_req <= 1'b0;
        repeat (10) @(posedge clk);
        @(negedge clk);
    endtask
    // k = {width, word select, byte select}; coding line is the inverse of word select
    task automatic setm(input logic [3:0] k);
        @(posedge clk);
        {bus_width_sel_hi, bus_width_sel_lo, pin_drv, pin_or_register_config} <= {k[3:2], k[0], k[1], ~k[1], k[1]};
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask
    // expected {enables, values} of the data lines
    function automatic logic [35:0] expl(input logic [3:0] k, input logic [17:0] r);
        casez (k)
            4'b00??: return {18'h3ffff, r};
            4'b010?: return {18'h3fffc, r[17:2], 2'h0};
            4'b011?: return {18'h3fffc, 14'h0, r[1:0], 2'h0};
            4'b1000: return {18'h3fc00, r[17:10], 10'h0};
            4'b1001: return {18'h3fc00, r[9:2], 10'h0};
            4'b1010: return {18'h3fc00, 6'h0, r[1:0], 10'h0};
            4'b1011: return {18'h3fc00, r[1:0], 16'h0};
            default: return 36'h0;
        endcase
    endfunction
    ////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b1, OBF_CFG_OFS, 32'h1b);
        wb(1'b0, OBF_CFG_OFS, 32'h0);
        chk("cfg", 32'h1b, q);
        wb(1'b0, 4'hc, 32'h0);
        chk("unmapped", 32'h0, q);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {ref_powerdown, buf_off} <= 2'(i);
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk("ref enable", {31'h0, ~i[1]}, ref_enable);
            chk("buf enable", {31'h0, ~(i[1] & i[0])}, ref_buf_enable);
        end
        // clock enable low: pin changes must not reach the outputs
        @(posedge clk);
        {clk_en, ref_powerdown} <= 2'b00;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("frozen ref", 32'h0, ref_enable);
        @(posedge clk);
        clk_en <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("thawed ref", 32'h1, ref_enable);
        $display("registers and reference done");
        @(posedge clk);
        res_valid <= 1'b1;
        res_data <= W0;
        @(posedge clk);
        res_valid <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            setm(4'(k));
            e = expl(4'(k), W0);
            chk("enables", 32'(e[35:18]), data_line_oe);
            chk("lines", 32'(e[17:0]), data_line_o & data_line_oe);
            chk("coding", k < 4 ? 32'h0 : {31'h0, ~k[1]}, output_coding_sel);
            chk("range", (k > 11 && !k[1]) ? 32'h3 : 32'h1, range_sel);
            chk("conv mode", (k > 11 && !k[1]) ? 32'h2 : 32'h1, conv_mode_sel);
            chk("serial", {31'h0, k > 11}, serial_if_en);
        end
        $display("bus modes done");
        setm(4'h0);
        @(posedge clk);
        res_valid <= 1'b1;
        res_data <= W0 + 18'h1;
        n = 0;
        repeat (30) begin
            @(negedge clk);
            if (res_ready === 1'b1)
                n++;
            @(posedge clk);
            res_data <= W0 + 18'(n) + 18'h1;
        end
        res_valid <= 1'b0;
        chk("words taken", 32'd16, n);
        chk("ready when full", 32'h0, res_ready);
        wb(1'b0, OBF_STAT_OFS, 32'h0);
        chk("fill level", 32'd16, 32'(q[20:16]));
        for (int i = 1; i <= 16; i++) begin
            rd();
            chk("drained word", 32'(W0 + 18'(i)), data_line_o);
        end
        wb(1'b0, OBF_STAT_OFS, 32'h0);
        chk("empty level", 32'h0, 32'(q[20:16]));
        $display("buffer done");
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk("lines in reset", 32'h0, data_line_o);
        chk("coding in reset", 32'h1, output_coding_sel);
        @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, OBF_CFG_OFS, 32'h0);
        chk("cfg cleared", 32'h0, q);
        $display("reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
